//--- design/occ_map.svh
// Purpose: Register offsets, field positions, reset values and unlock keys of the oscillator control block
// Assumes: Included by its bare name wherever a value is needed
// Notes: Key values are arbitrary and only need to differ from each other
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// ==========================================
// Register offsets (byte addresses)
`define OCC_OFS_CTRL 8'h00
`define OCC_OFS_UNLOCK 8'h04

// ==========================================
// Unlock keys, written back to back
`define OCC_KEY_FIRST 32'hAA99_6655
`define OCC_KEY_SECOND 32'h5566_99AA

// ==========================================
// Field positions (least significant bit)
`define OCC_POS_PLL_POST_DIV 27
`define OCC_POS_FAST_RC_DIV 24
`define OCC_POS_SOSC_READY 22
`define OCC_POS_PB_DIV_READY 21
`define OCC_POS_PB_DIV 19
`define OCC_POS_PLL_MULT 16
`define OCC_POS_CUR_OSC 12
`define OCC_POS_NEW_OSC 8
`define OCC_POS_CLK_LOCK 7
`define OCC_POS_USB_LOCK 6
`define OCC_POS_SYS_LOCK 5
`define OCC_POS_SLEEP 4
`define OCC_POS_CLK_FAIL 3
`define OCC_POS_USB_FRC 2
`define OCC_POS_SOSC_EN 1
`define OCC_POS_OSC_SWITCH 0

// ==========================================
// Reset values before configuration load
`define OCC_RST_FAST_RC_DIV 3'h1
`define OCC_RST_PB_DIV 2'h3
`define OCC_RST_PLL_POST_DIV 3'h0

`endif

//--- design/occ_peripheral_bus_clock_div.sv
// Purpose: Peripheral bus clock enable divider with clean divisor changes
// Assumes: One system clock; tick_o is used as a clock enable downstream
// Notes: A new divisor takes effect only at a period boundary
`timescale 1ns/1ps
`include "occ_map.svh"
module occ_peripheral_bus_clock_div
    import occ_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [1:0] sel_i,
    output logic tick_o,
    output logic ready_o
);

    occ_div_state_t q; // Registered state
    occ_div_state_t d; // Next state

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        if (ce_i) begin
            if (q.cnt == 3'h0) begin
                d.cur = sel_i;
                d.cnt = 3'((4'h1 << sel_i) - 4'h1);
            end else begin
                d.cnt = q.cnt - 3'h1;
            end
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{cur: `OCC_RST_PB_DIV, cnt: 3'h0};
        end else begin
            q <= d;
        end
    end

    // Tick on last count of each period
    assign tick_o = ce_i && (q.cnt == 3'h0);
    assign ready_o = (q.cur == sel_i);

    // ==========================================
    // Checks
    a_no_runt_switch: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.cur != $past(q.cur)) |-> ($past(q.cnt) == 3'h0 && $past(ce_i)))
        else $error("divisor changed mid period");
    a_div8_spacing: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && tick_o && q.cur == 2'h3 && sel_i == 2'h3) |=> (q.cnt == 3'h7))
        else $error("divide by eight period wrong");
endmodule

//--- design/occ_pkg.sv
// Purpose: Types shared by the oscillator control block
// Assumes: Constants live in occ_map.svh
// Notes: Ratios are whole divide factors, 1 to 256
package occ_pkg;

    // ==========================================
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;   // Byte address
        logic [31:0] wdata; // Write data
        logic wr;           // Write strobe
        logic rd;           // Read strobe
    } occ_bus_req_t;

    // ==========================================
    // Software-visible control fields
    typedef struct packed {
        logic [2:0] pll_post_divider;
        logic [2:0] fast_rc_divider;
        logic [1:0] periph_bus_divisor;
        logic [2:0] pll_multiplier;
        logic [2:0] new_osc_select;
        logic clock_select_lock;
        logic sleep_on_wait;
        logic clock_fail_flag;
        logic usb_fast_rc_select;
        logic secondary_osc_enable;
        logic osc_switch_request;
    } occ_ctrl_t;

    // Configuration fields caught after reset
    typedef struct packed {
        logic [2:0] pll_post_divider;
        logic [1:0] periph_bus_divisor;
        logic [2:0] pll_multiplier;
        logic [2:0] new_osc_select;
        logic secondary_osc_enable;
    } occ_cfg_t;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        OCC_LOCKED,
        OCC_HALF,
        OCC_OPEN
    } occ_unlock_t;

    // All state of the top module
    typedef struct packed {
        occ_ctrl_t ctrl;
        occ_unlock_t unlock;
        logic loaded;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sosc_ready;
        logic [31:0] rdata;
    } occ_state_t;

    // All state of the peripheral clock divider
    typedef struct packed {
        logic [1:0] cur;
        logic [2:0] cnt;
    } occ_div_state_t;

    // Divide code to ratio: powers of two, top code is 256
    function automatic logic [8:0] occ_ratio(input logic [2:0] code);
        occ_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
    endfunction

endpackage

//--- design/occ_top.sv
// Purpose: Oscillator control register and clock divider settings
// Assumes: Plain register port; status inputs from analog parts are asynchronous
// Notes: Configuration inputs are caught in the first enabled cycle after reset
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "occ_map.svh"
module occ_top
    import occ_pkg::*;
#(
    parameter bit HAS_USB = 1'b1 // Variant carries the USB peripheral
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire occ_bus_req_t bus_i,
    output logic [31:0] read_data_o,
    input wire occ_cfg_t cfg_i,
    input wire logic [2:0] cur_osc_i,
    input wire logic sosc_stable_i,
    input wire logic sys_pll_lock_i,
    input wire logic usb_pll_lock_i,
    output occ_ctrl_t ctrl_o,
    output logic [8:0] pll_div_ratio_o,
    output logic [8:0] frc_div_ratio_o,
    output logic periph_tick_o,
    output logic periph_divisor_ready_o,
    output logic secondary_osc_ready_o
);

    occ_state_t q; // Registered state
    occ_state_t d; // Next state
    logic div_ready; // Divider has no change pending

    // ==========================================
    // Peripheral bus clock divider
    occ_peripheral_bus_clock_div u_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sel_i(q.ctrl.periph_bus_divisor),
        .tick_o(periph_tick_o),
        .ready_o(div_ready)
    );

    // ==========================================
    // Next state
    always_comb begin
        logic [31:0] w; // Read word under construction
        w = 32'h0;
        d = q;
        if (ce_i) begin
            // Two-stage capture of asynchronous status
            d.sync1 = {usb_pll_lock_i, sys_pll_lock_i, sosc_stable_i};
            d.sync2 = q.sync1;
            // ready only when enabled and stable
            d.sosc_ready = q.sync2[0] & q.ctrl.secondary_osc_enable;
            // Catch configuration once after reset
            if (!q.loaded) begin
                d.loaded = 1'b1;
                d.ctrl.pll_post_divider = cfg_i.pll_post_divider;
                d.ctrl.periph_bus_divisor = cfg_i.periph_bus_divisor;
                d.ctrl.pll_multiplier = cfg_i.pll_multiplier;
                d.ctrl.new_osc_select = cfg_i.new_osc_select;
                d.ctrl.secondary_osc_enable = cfg_i.secondary_osc_enable;
            end
            // Writes to the unlock key register
            if (bus_i.wr && bus_i.addr == `OCC_OFS_UNLOCK) begin
                if (bus_i.wdata == `OCC_KEY_FIRST) begin
                    d.unlock = OCC_HALF;
                end else if (q.unlock == OCC_HALF && bus_i.wdata == `OCC_KEY_SECOND) begin
                    d.unlock = OCC_OPEN;
                end else begin
                    d.unlock = OCC_LOCKED;
                end
            end else if (bus_i.wr) begin
                // Any other write relocks
                d.unlock = OCC_LOCKED;
                // only an opened register takes writes
                if (bus_i.addr == `OCC_OFS_CTRL && q.unlock == OCC_OPEN) begin
                    d.ctrl.pll_post_divider = bus_i.wdata[`OCC_POS_PLL_POST_DIV +: 3];
                    d.ctrl.fast_rc_divider = bus_i.wdata[`OCC_POS_FAST_RC_DIV +: 3];
                    d.ctrl.pll_multiplier = bus_i.wdata[`OCC_POS_PLL_MULT +: 3];
                    d.ctrl.new_osc_select = bus_i.wdata[`OCC_POS_NEW_OSC +: 3];
                    d.ctrl.clock_select_lock = bus_i.wdata[`OCC_POS_CLK_LOCK];
                    d.ctrl.sleep_on_wait = bus_i.wdata[`OCC_POS_SLEEP];
                    d.ctrl.clock_fail_flag = bus_i.wdata[`OCC_POS_CLK_FAIL];
                    d.ctrl.secondary_osc_enable = bus_i.wdata[`OCC_POS_SOSC_EN];
                    d.ctrl.osc_switch_request = bus_i.wdata[`OCC_POS_OSC_SWITCH];
                    d.ctrl.usb_fast_rc_select = HAS_USB & bus_i.wdata[`OCC_POS_USB_FRC];
                    if (div_ready) begin
                        d.ctrl.periph_bus_divisor = bus_i.wdata[`OCC_POS_PB_DIV +: 2];
                    end
                end
            end else if (bus_i.rd && q.unlock == OCC_HALF) begin
                // Key pair broken by a read
                d.unlock = OCC_LOCKED;
            end
            // Read word assembly
            if (bus_i.addr == `OCC_OFS_CTRL) begin
                w[`OCC_POS_PLL_POST_DIV +: 3] = q.ctrl.pll_post_divider;
                w[`OCC_POS_FAST_RC_DIV +: 3] = q.ctrl.fast_rc_divider;
                w[`OCC_POS_SOSC_READY] = q.sosc_ready;
                w[`OCC_POS_PB_DIV_READY] = div_ready;
                w[`OCC_POS_PB_DIV +: 2] = q.ctrl.periph_bus_divisor;
                w[`OCC_POS_PLL_MULT +: 3] = q.ctrl.pll_multiplier;
                w[`OCC_POS_CUR_OSC +: 3] = cur_osc_i;
                w[`OCC_POS_NEW_OSC +: 3] = q.ctrl.new_osc_select;
                w[`OCC_POS_CLK_LOCK] = q.ctrl.clock_select_lock;
                w[`OCC_POS_USB_LOCK] = HAS_USB & q.sync2[2];
                w[`OCC_POS_SYS_LOCK] = q.sync2[1];
                w[`OCC_POS_SLEEP] = q.ctrl.sleep_on_wait;
                w[`OCC_POS_CLK_FAIL] = q.ctrl.clock_fail_flag;
                w[`OCC_POS_USB_FRC] = q.ctrl.usb_fast_rc_select;
                w[`OCC_POS_SOSC_EN] = q.ctrl.secondary_osc_enable;
                w[`OCC_POS_OSC_SWITCH] = q.ctrl.osc_switch_request;
            end else if (bus_i.addr == `OCC_OFS_UNLOCK) begin
                w[0] = (q.unlock == OCC_OPEN);
            end
            // Read data valid only in the cycle after the strobe
            d.rdata = bus_i.rd ? w : 32'h0;
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            // fast RC divides by two at reset
            q.ctrl.fast_rc_divider <= `OCC_RST_FAST_RC_DIV;
            q.ctrl.periph_bus_divisor <= `OCC_RST_PB_DIV;
            q.ctrl.pll_post_divider <= `OCC_RST_PLL_POST_DIV;
            q.unlock <= OCC_LOCKED;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs
    assign read_data_o = q.rdata;
    assign ctrl_o = q.ctrl;
    assign pll_div_ratio_o = occ_ratio(q.ctrl.pll_post_divider);
    assign frc_div_ratio_o = occ_ratio(q.ctrl.fast_rc_divider);
    assign periph_divisor_ready_o = div_ready;
    assign secondary_osc_ready_o = q.sosc_ready;

    // ==========================================
    // Checks
    a_reserved_reads_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(ce_i) && $past(bus_i.rd) |-> (read_data_o[31:30] == 2'h0 && read_data_o[23] == 1'b0))
        else $error("reserved bits read nonzero");
    a_locked_write_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && q.loaded && bus_i.wr && bus_i.addr == `OCC_OFS_CTRL && q.unlock != OCC_OPEN) |=>
        (q.ctrl == $past(q.ctrl)))
        else $error("locked write changed control");
    a_open_write_relocks: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && bus_i.wr && bus_i.addr == `OCC_OFS_CTRL) |=> (q.unlock == OCC_LOCKED))
        else $error("unlock survived a write");
    a_periph_bus_divisor_guard: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && q.loaded && bus_i.wr && !div_ready) |=>
        (q.ctrl.periph_bus_divisor == $past(q.ctrl.periph_bus_divisor)))
        else $error("divisor written while not ready");
    a_ready_low_pending: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.ctrl.periph_bus_divisor != $past(q.ctrl.periph_bus_divisor)) |-> !periph_divisor_ready_o)
        else $error("ready high during divisor change");
    a_sosc_off_not_ready: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !q.ctrl.secondary_osc_enable) |=> !secondary_osc_ready_o)
        else $error("oscillator ready while disabled");
    a_frc_reset_value: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(rst_i) |-> (frc_div_ratio_o == 9'h002))
        else $error("fast RC reset divide not two");
    a_pll_top_code: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.ctrl.pll_post_divider == 3'h7) |-> (pll_div_ratio_o == 9'h100))
        else $error("top post divider code not 256");
    a_usb_absent: assert property (@(posedge clock_i) disable iff (rst_i)
        !HAS_USB |-> !q.ctrl.usb_fast_rc_select)
        else $error("USB select set on variant without USB");
    // Divide factors of the remaining codes
    a_pll_low_codes: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.ctrl.pll_post_divider != 3'h7) |-> (pll_div_ratio_o == (9'h001 << q.ctrl.pll_post_divider)))
        else $error("post divider factor not a power of two");
    a_frc_low_codes: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.ctrl.fast_rc_divider != 3'h7) |-> (frc_div_ratio_o == (9'h001 << q.ctrl.fast_rc_divider)))
        else $error("fast RC factor not a power of two");
    a_frc_top_code: assert property (@(posedge clock_i) disable iff (rst_i)
        (q.ctrl.fast_rc_divider == 3'h7) |-> (frc_div_ratio_o == 9'h100))
        else $error("top fast RC code not 256");
    // Ready flags follow their sources into the read word
    a_sosc_needs_sync: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && !q.sync2[0]) |=> !secondary_osc_ready_o)
        else $error("oscillator ready without stable status");
    a_sosc_bit_read: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(ce_i) && $past(bus_i.rd) && $past(bus_i.addr) == `OCC_OFS_CTRL) |->
        (read_data_o[`OCC_POS_SOSC_READY] == $past(secondary_osc_ready_o)))
        else $error("oscillator ready bit misread");
    a_ready_bit_read: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(ce_i) && $past(bus_i.rd) && $past(bus_i.addr) == `OCC_OFS_CTRL) |->
        (read_data_o[`OCC_POS_PB_DIV_READY] == $past(periph_divisor_ready_o)))
        else $error("divisor ready bit misread");
    // Key pair and variant checks
    a_key_pair_opens: assert property (@(posedge clock_i) disable iff (rst_i)
        (ce_i && bus_i.wr && bus_i.addr == `OCC_OFS_UNLOCK && q.unlock == OCC_HALF &&
        bus_i.wdata == `OCC_KEY_SECOND) |=> (q.unlock == OCC_OPEN))
        else $error("second key did not open");
    a_usb_lock_absent: assert property (@(posedge clock_i) disable iff (rst_i)
        (!HAS_USB && $past(ce_i) && $past(bus_i.rd)) |-> !read_data_o[`OCC_POS_USB_LOCK])
        else $error("USB lock read on variant without USB");
endmodule

//--- verification/occ_top_tb.sv
// Purpose: Self-checking bench for the oscillator control register block
// Assumes: Bench drives bus_i and status inputs at rising edges; ce_i high except in the freeze scenario
// Notes: Each scenario is a task; verdict printed by results
`timescale 1ns/1ps
`include "occ_map.svh"
module occ_top_tb
    import occ_pkg::*;
;
    // ==========================================
    // Stimulus and observed signals
    logic clock_i = 1'b0; // System clock
    logic rst_i = 1'b1; // Async reset
    occ_bus_req_t bus = '0; // Register request
    occ_cfg_t cfg = '{3'h2, 2'h3, 3'h4, 3'h1, 1'b1}; // Configuration fields
    logic sosc_stable = 1'b0; // Secondary oscillator status
    logic sys_lock = 1'b0; // System PLL lock
    logic usb_lock = 1'b0; // USB PLL lock
    logic [31:0] rdata; // Read word
    occ_ctrl_t ctrl; // Control fields
    logic [8:0] pll_ratio; // PLL divide factor
    logic [8:0] frc_ratio; // RC divide factor
    logic tick; // Peripheral clock enable
    logic pb_ready; // Divisor ready
    logic sosc_ready; // Secondary oscillator ready
    logic ce = 1'b1; // Clock enable
    logic [31:0] nu_rdata; // Read word of variant without USB
    occ_ctrl_t nu_ctrl; // Control fields of variant without USB
    int bad_count = 0; // Mismatches
    int cmp_count = 0; // Comparisons

    // Clock of 100 ns period
    always #50 clock_i = ~clock_i;

    // Variant without the USB peripheral, same stimulus
    occ_top #(.HAS_USB(1'b0)) u_no_usb (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus),
        .read_data_o(nu_rdata), .cfg_i(cfg), .cur_osc_i(3'h5), .sosc_stable_i(sosc_stable),
        .sys_pll_lock_i(sys_lock), .usb_pll_lock_i(usb_lock), .ctrl_o(nu_ctrl), .pll_div_ratio_o(),
        .frc_div_ratio_o(), .periph_tick_o(), .periph_divisor_ready_o(), .secondary_osc_ready_o());

    occ_top DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus), .read_data_o(rdata), .cfg_i(cfg),
        .cur_osc_i(3'h5), .sosc_stable_i(sosc_stable), .sys_pll_lock_i(sys_lock), .usb_pll_lock_i(usb_lock),
        .ctrl_o(ctrl), .pll_div_ratio_o(pll_ratio), .frc_div_ratio_o(frc_ratio), .periph_tick_o(tick),
        .periph_divisor_ready_o(pb_ready), .secondary_osc_ready_o(sosc_ready));

    // ==========================================
    // Compare and report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    task automatic idle();
        @(posedge clock_i);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        idle();
        d = rdata;
    endtask

    // Key pair then one control write, back to back
    task automatic unlock_ctrl(input logic [31:0] d);
        wr(`OCC_OFS_UNLOCK, `OCC_KEY_FIRST);
        wr(`OCC_OFS_UNLOCK, `OCC_KEY_SECOND);
        wr(`OCC_OFS_CTRL, d);
    endtask

    // Control word with fixed multiplier, new select and oscillator enable
    function automatic logic [31:0] mkw(input logic [2:0] pll, input logic [2:0] fast_internal_rc_osc, input logic [1:0] pb);
        mkw = ({29'h0, pll} << 27) | ({29'h0, fast_internal_rc_osc} << 24) | ({30'h0, pb} << 19) | 32'h0004_0102;
    endfunction

    // Bounded wait on a ready flag: 0 divisor, 1 oscillator
    task automatic wait_hi(input bit which);
        int n;
        n = 0;
        while ((which ? sosc_ready : pb_ready) !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 40) begin
                bad_count++;
                $display("CHECK FAILED at %0t: ready wait timed out", $time);
                results();
            end
        end
    endtask

    task automatic count_ticks(input int cycles, output int c);
        c = 0;
        repeat (cycles) begin
            if (tick === 1'b1) c++;
            @(posedge clock_i);
            #1;
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_codes();
        logic [8:0] e;
        for (int i = 0; i < 8; i++) begin
            unlock_ctrl(mkw(i[2:0], 3'(7 - i), 2'h3));
            idle();
            e = (i == 7) ? 9'h100 : 9'h001 << i;
            cmp({23'h0, pll_ratio}, {23'h0, e}, "pll ratio");
            e = (i == 0) ? 9'h100 : 9'h001 << (7 - i);
            cmp({23'h0, frc_ratio}, {23'h0, e}, "frc ratio");
        end
    endtask

    task automatic t_locked();
        wr(`OCC_OFS_CTRL, mkw(3'h1, 3'h1, 2'h3));
        idle();
        cmp({29'h0, ctrl.pll_post_divider}, 32'h7, "write without unlock");
    endtask

    task automatic t_divisor();
        int n;
        for (int c = 0; c < 4; c++) begin
            unlock_ctrl(mkw(3'h0, 3'h1, c[1:0]));
            idle();
            wait_hi(1'b0);
            count_ticks(32, n);
            cmp(n, 32 >> c, "tick count");
        end
        n = 0;
        while (tick !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (tick !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: tick wait timed out", $time);
            results();
        end
        unlock_ctrl(mkw(3'h0, 3'h1, 2'h0));
        unlock_ctrl(mkw(3'h0, 3'h1, 2'h2));
        idle();
        wait_hi(1'b0);
        cmp({30'h0, ctrl.periph_bus_divisor}, 32'h0, "divisor written while busy");
        count_ticks(16, n);
        cmp(n, 16, "tick count after change");
    endtask

    task automatic t_bits();
        logic [31:0] d;
        @(posedge clock_i);
        sosc_stable <= 1'b1;
        usb_lock <= 1'b1;
        sys_lock <= 1'b1;
        wait_hi(1'b1);
        unlock_ctrl(32'hFFFF_FF7F);
        idle();
        wait_hi(1'b0);
        rd(`OCC_OFS_CTRL, d);
        cmp(d & 32'hC080_0000, 32'h0, "unimplemented bits");
        cmp_bit(d[22], 1'b1, "oscillator ready bit");
        cmp_bit(d[6], 1'b1, "usb lock bit");
        cmp_bit(d[2], 1'b1, "usb select bit");
        cmp_bit(nu_rdata[6], 1'b0, "usb lock bit without usb");
        cmp_bit(nu_rdata[2], 1'b0, "usb select bit without usb");
        cmp_bit(nu_ctrl.usb_fast_rc_select, 1'b0, "usb select without usb");
        unlock_ctrl(32'hFFFF_FF7D);
        idle();
        repeat (4) @(posedge clock_i);
        #1;
        cmp_bit(sosc_ready, 1'b0, "oscillator ready after disable");
    endtask

    // Clock enable low: divider stops and bus strobes are lost
    task automatic t_freeze();
        @(posedge clock_i);
        ce <= 1'b0;
        unlock_ctrl(mkw(3'h0, 3'h1, 2'h3));
        idle();
        cmp_bit(tick, 1'b0, "tick while frozen");
        cmp({29'h0, ctrl.pll_post_divider}, 32'h7, "write while frozen");
        @(posedge clock_i);
        ce <= 1'b1;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] d;
        repeat (3) @(posedge clock_i);
        #1;
        cmp({29'h0, ctrl.fast_rc_divider}, 32'h1, "rc divider in reset");
        cmp({23'h0, frc_ratio}, 32'h2, "rc ratio in reset");
        @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rd(`OCC_OFS_CTRL, d);
        cmp(d, 32'h113C_5102, "word after reset");
        cmp_bit(pb_ready, 1'b1, "divisor ready idle");
        t_codes();
        t_locked();
        t_divisor();
        t_bits();
        t_freeze();
        results();
    end
endmodule
